// file: verilog/sbs_sram_io.sv
// pin-level behaviour of a split-port two-word burst sram, in the core clock
// assumes: pin clocks run well below a quarter of core_clk_i, so every pin edge
// is seen as a separate synchronised event; no reset pin, reset_i is core-side
//
// Notes on behaviour
// - write data taken on both input clock edges
// - low write select starts write, high ignores
// - each lane select gates one nine-bit lane
// - lane selects sampled with each data beat
// - read address positive edge, write address negative
// - address width 21, 20, 19 per config
// - address ignored when its port is deselected
// - low read select starts two-word burst read
// - pending read completes, then outputs float
// - read data launched on output clock edges, on input clock edges in single clock mode
// - outputs float while no read burst is pending or being launched
// - accesses begin on positive input clock edge
// - pll disable selects single-cycle latency mode
module sbs_sram_io
   import sbs_pkg::*;
#(
   parameter int DATA_W = DATA_W_X36,
   parameter int ADDR_W = addr_w_for(DATA_W)
) (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic in_clk_i,
   input wire logic in_clk_n_i,
   input wire logic out_clk_i,
   input wire logic out_clk_n_i,
   input wire logic single_clk_mode_i,
   input wire logic pll_disable_n_i,
   input wire logic write_port_select_n_i,
   input wire logic read_port_select_n_i,
   input wire logic [DATA_W/LANE_W-1:0] byte_lane_write_select_n_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] write_data_i,
   output logic [DATA_W-1:0] read_data_o,
   output logic read_data_oe_o
);

   localparam int LANES = DATA_W / LANE_W;
   localparam int SYNC_W = 8 + LANES + ADDR_W + DATA_W;

   //////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [SYNC_W-1:0] sync_reg [SYNC_STAGES]; // stage 0 is read by stage 1 only
   logic [SYNC_W-1:0] sync_next [SYNC_STAGES];
   logic [3:0] clk_hist_reg;                  // previous level of the four pin clocks
   logic [3:0] clk_hist_next;
   logic k_s, kn_s, c_s, cn_s;                // synchronised pin clocks
   logic wps_s, rps_s, single_s, plldis_s;    // synchronised selects and straps
   logic [LANES-1:0] bws_s;
   logic [ADDR_W-1:0] addr_s;
   logic [DATA_W-1:0] wdata_s;
   logic k_rise, kn_rise, pos_out_rise, neg_out_rise;

   // every pin passes the same depth so data stay aligned with their clock edge
   always_comb begin
      sync_next[0] = {in_clk_i, in_clk_n_i, out_clk_i, out_clk_n_i,
                      write_port_select_n_i, read_port_select_n_i,
                      single_clk_mode_i, pll_disable_n_i,
                      byte_lane_write_select_n_i, addr_i, write_data_i};
      for (int s = 1; s < SYNC_STAGES; s++) begin
         sync_next[s] = sync_reg[s-1];
      end
      clk_hist_next = {k_s, kn_s, c_s, cn_s};
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         for (int s = 0; s < SYNC_STAGES; s++) begin
            sync_reg[s] <= '0;
         end
         clk_hist_reg <= '0;
      end else begin
         sync_reg <= sync_next;
         clk_hist_reg <= clk_hist_next;
      end
   end

   assign {k_s, kn_s, c_s, cn_s, wps_s, rps_s, single_s, plldis_s,
           bws_s, addr_s, wdata_s} = sync_reg[SYNC_STAGES-1];

   // edges of the pin clocks, from the last synchroniser stage only
   assign k_rise = k_s & ~clk_hist_reg[3];
   assign kn_rise = kn_s & ~clk_hist_reg[2];
   // single clock mode reuses the input pair for launch, else the output pair
   assign pos_out_rise = single_s ? k_rise : (c_s & ~clk_hist_reg[1]);
   assign neg_out_rise = single_s ? kn_rise : (cn_s & ~clk_hist_reg[0]);

   //////////////////////////////////////////////////////////////////////////////
   // write port
   sbs_wr_state_t wr_state_reg, wr_state_next;
   logic [DATA_W-1:0] b0_data_reg, b0_data_next;      // first beat waits for the address
   logic [LANES-1:0] b0_mask_reg, b0_mask_next;
   logic [DATA_W-1:0] b1_data_reg, b1_data_next;
   logic [LANES-1:0] b1_mask_reg, b1_mask_next;
   logic [ADDR_W-1:0] wr_addr_reg, wr_addr_next;
   logic mem_wr_en_reg, mem_wr_en_next;
   logic [ADDR_W:0] mem_wr_addr_reg, mem_wr_addr_next;
   logic [DATA_W-1:0] mem_wr_data_reg, mem_wr_data_next;
   logic [LANES-1:0] mem_wr_lane_n_reg, mem_wr_lane_n_next;

   // the write address arrives half a cycle after the first beat, so the first
   // beat is parked and both beats go to the array on the two following cycles
   always_comb begin
      wr_state_next = wr_state_reg;
      b0_data_next = b0_data_reg;
      b0_mask_next = b0_mask_reg;
      b1_data_next = b1_data_reg;
      b1_mask_next = b1_mask_reg;
      wr_addr_next = wr_addr_reg;
      mem_wr_en_next = 1'h0;
      mem_wr_addr_next = mem_wr_addr_reg;
      mem_wr_data_next = mem_wr_data_reg;
      mem_wr_lane_n_next = mem_wr_lane_n_reg;
      unique case (wr_state_reg)
         WR_IDLE: begin
            // write starts only on a positive edge with the select low
            if (k_rise && !wps_s) begin
               b0_data_next = wdata_s;      // first beat with its own mask
               b0_mask_next = bws_s;
               wr_state_next = WR_BEAT0;
            end
         end
         WR_BEAT0: begin
            // second beat and address come on the next negative edge
            if (kn_rise) begin
               wr_addr_next = addr_s;       // write address on the negative edge
               b1_data_next = wdata_s;      // second beat with its own mask
               b1_mask_next = bws_s;
               mem_wr_en_next = 1'h1;
               mem_wr_addr_next = {addr_s, BEAT0_SEL};
               mem_wr_data_next = b0_data_reg;
               mem_wr_lane_n_next = b0_mask_reg;
               wr_state_next = WR_BEAT1;
            end
         end
         WR_BEAT1: begin
            mem_wr_en_next = 1'h1;
            mem_wr_addr_next = {wr_addr_reg, BEAT1_SEL};
            mem_wr_data_next = b1_data_reg;
            mem_wr_lane_n_next = b1_mask_reg;
            wr_state_next = WR_IDLE;
         end
         default: begin
            wr_state_next = WR_IDLE;        // illegal code, recover quietly
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         wr_state_reg <= WR_IDLE;
         b0_data_reg <= '0;
         b0_mask_reg <= '1;
         b1_data_reg <= '0;
         b1_mask_reg <= '1;
         wr_addr_reg <= '0;
         mem_wr_en_reg <= 1'h0;
         mem_wr_addr_reg <= '0;
         mem_wr_data_reg <= '0;
         mem_wr_lane_n_reg <= '1;
      end else begin
         wr_state_reg <= wr_state_next;
         b0_data_reg <= b0_data_next;
         b0_mask_reg <= b0_mask_next;
         b1_data_reg <= b1_data_next;
         b1_mask_reg <= b1_mask_next;
         wr_addr_reg <= wr_addr_next;
         mem_wr_en_reg <= mem_wr_en_next;
         mem_wr_addr_reg <= mem_wr_addr_next;
         mem_wr_data_reg <= mem_wr_data_next;
         mem_wr_lane_n_reg <= mem_wr_lane_n_next;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // read fetch
   logic [2:0] fetch_reg, fetch_next;          // one-hot position in the two-word fetch
   logic [ADDR_W-1:0] rd_addr_reg, rd_addr_next;
   logic mem_rd_en_reg, mem_rd_en_next;
   logic [ADDR_W:0] mem_rd_addr_reg, mem_rd_addr_next;
   logic [DATA_W-1:0] mem_rd_data;
   logic [DATA_W-1:0] slot_w0_reg, slot_w0_next;   // fetched burst awaiting launch
   logic [DATA_W-1:0] slot_w1_reg, slot_w1_next;
   logic slot_full_reg, slot_full_next;
   logic launch;                                    // output side takes the slot

   // a deselected read leaves the address alone; a fetch already running goes on
   always_comb begin
      fetch_next = {fetch_reg[1:0], 1'h0};
      rd_addr_next = rd_addr_reg;
      mem_rd_en_next = 1'h0;
      mem_rd_addr_next = mem_rd_addr_reg;
      slot_w0_next = slot_w0_reg;
      slot_w1_next = slot_w1_reg;
      slot_full_next = slot_full_reg;
      if (k_rise && !rps_s) begin
         // read address on the positive edge, burst of two words
         rd_addr_next = addr_s;
         mem_rd_en_next = 1'h1;
         mem_rd_addr_next = {addr_s, BEAT0_SEL};
         fetch_next = 3'h1;
      end else if (fetch_reg[0]) begin
         mem_rd_en_next = 1'h1;
         mem_rd_addr_next = {rd_addr_reg, BEAT1_SEL};
      end
      // a high select leaves rd_addr untouched
      if (fetch_reg[1]) begin
         slot_w0_next = mem_rd_data;
      end
      // filling wins over the launch that empties the slot
      if (fetch_reg[2]) begin
         slot_w1_next = mem_rd_data;
         slot_full_next = 1'h1;
      end else if (launch) begin
         slot_full_next = 1'h0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         fetch_reg <= '0;
         rd_addr_reg <= '0;
         mem_rd_en_reg <= 1'h0;
         mem_rd_addr_reg <= '0;
         slot_w0_reg <= '0;
         slot_w1_reg <= '0;
         slot_full_reg <= 1'h0;
      end else begin
         fetch_reg <= fetch_next;
         rd_addr_reg <= rd_addr_next;
         mem_rd_en_reg <= mem_rd_en_next;
         mem_rd_addr_reg <= mem_rd_addr_next;
         slot_w0_reg <= slot_w0_next;
         slot_w1_reg <= slot_w1_next;
         slot_full_reg <= slot_full_next;
      end
   end

   sbs_burst_mem #(
      .DATA_W(DATA_W),
      .WORD_AW(ADDR_W + 1)
   ) u_mem (
      .core_clk_i(core_clk_i),
      .wr_en_i(mem_wr_en_reg),
      .wr_addr_i(mem_wr_addr_reg),
      .wr_data_i(mem_wr_data_reg),
      .wr_lane_n_i(mem_wr_lane_n_reg),
      .rd_en_i(mem_rd_en_reg),
      .rd_addr_i(mem_rd_addr_reg),
      .rd_data_o(mem_rd_data)
   );

   //////////////////////////////////////////////////////////////////////////////
   // read data launch
   sbs_rd_state_t rd_state_reg, rd_state_next;
   logic [DATA_W-1:0] out_data_reg, out_data_next;
   logic out_oe_reg, out_oe_next;
   logic [DATA_W-1:0] hold_w1_reg, hold_w1_next;  // second word kept so the staging pair can refill
   logic [DATA_W-1:0] nxt_w0_reg, nxt_w0_next;    // staged burst, frees the slot before its edge
   logic [DATA_W-1:0] nxt_w1_reg, nxt_w1_next;
   logic nxt_full_reg, nxt_full_next;
   logic beat0_edge, beat1_edge;

   // pll running: first word half a cycle later, on the negative output edge;
   // pll off: first word on the positive edge, the shorter latency
   assign beat0_edge = plldis_s ? neg_out_rise : pos_out_rise;
   assign beat1_edge = plldis_s ? pos_out_rise : neg_out_rise;

   always_comb begin
      rd_state_next = rd_state_reg;
      out_data_next = out_data_reg;
      out_oe_next = out_oe_reg;
      hold_w1_next = hold_w1_reg;
      nxt_w0_next = nxt_w0_reg;
      nxt_w1_next = nxt_w1_reg;
      nxt_full_next = nxt_full_reg;
      // back-to-back reads refill the slot before the late launch edge, so the
      // slot moves to the staging pair as soon as that pair is free
      launch = slot_full_reg && !nxt_full_reg;
      if (launch) begin
         nxt_w0_next = slot_w0_reg;
         nxt_w1_next = slot_w1_reg;
         nxt_full_next = 1'h1;
      end
      unique case (rd_state_reg)
         RD_IDLE: begin
            out_oe_next = 1'h0;               // no burst staged, outputs float
            if (nxt_full_reg) begin
               rd_state_next = RD_WAIT;
            end
         end
         RD_WAIT: begin
            if (beat0_edge) begin
               // first word leaves on its launch edge
               out_data_next = nxt_w0_reg;
               hold_w1_next = nxt_w1_reg;
               out_oe_next = 1'h1;
               nxt_full_next = 1'h0;
               rd_state_next = RD_BEAT_A;
            end
         end
         RD_BEAT_A: begin
            if (beat1_edge) begin
               out_data_next = hold_w1_reg;   // second word on the other edge
               rd_state_next = RD_BEAT_B;
            end
         end
         RD_BEAT_B: begin
            if (beat0_edge && nxt_full_reg) begin
               // back-to-back burst keeps the drivers on
               out_data_next = nxt_w0_reg;
               hold_w1_next = nxt_w1_reg;
               nxt_full_next = 1'h0;
               rd_state_next = RD_BEAT_A;
            end else if (pos_out_rise) begin
               // float after the following positive output edge
               out_oe_next = 1'h0;
               rd_state_next = nxt_full_reg ? RD_WAIT : RD_IDLE;
            end
         end
         default: begin
            out_oe_next = 1'h0;
            rd_state_next = RD_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         rd_state_reg <= RD_IDLE;
         out_data_reg <= '0;
         out_oe_reg <= 1'h0;
         hold_w1_reg <= '0;
         nxt_w0_reg <= '0;
         nxt_w1_reg <= '0;
         nxt_full_reg <= 1'h0;
      end else begin
         rd_state_reg <= rd_state_next;
         out_data_reg <= out_data_next;
         out_oe_reg <= out_oe_next;
         hold_w1_reg <= hold_w1_next;
         nxt_w0_reg <= nxt_w0_next;
         nxt_w1_reg <= nxt_w1_next;
         nxt_full_reg <= nxt_full_next;
      end
   end

   assign read_data_o = out_data_reg;
   assign read_data_oe_o = out_oe_reg;

   //////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);

   a_wr_deselect_ignored:
      assert property (wr_state_reg == WR_IDLE && k_rise && wps_s |=> wr_state_reg == WR_IDLE)
      else $error("write started with write select high");

   a_wr_beat0_capture:
      assert property (wr_state_reg == WR_IDLE && k_rise && !wps_s
                       |=> b0_data_reg == $past(wdata_s) && b0_mask_reg == $past(bws_s))
      else $error("first write beat not captured");

   a_wr_burst_addr:
      assert property (wr_state_reg == WR_BEAT0 && kn_rise
                       |=> mem_wr_en_reg && mem_wr_addr_reg == {$past(addr_s), BEAT0_SEL}
                       ##1 mem_wr_en_reg && mem_wr_addr_reg == {$past(addr_s, 2), BEAT1_SEL})
      else $error("write burst address wrong");

   a_wr_lane_beat:
      assert property (wr_state_reg == WR_BEAT0 && kn_rise
                       |=> mem_wr_lane_n_reg == $past(b0_mask_reg)
                       ##1 mem_wr_lane_n_reg == $past(bws_s, 2))
      else $error("lane mask not paired with its beat");

   a_rd_fetch_pair:
      assert property (k_rise && !rps_s
                       |=> mem_rd_en_reg && mem_rd_addr_reg == {$past(addr_s), BEAT0_SEL}
                       ##1 mem_rd_en_reg && mem_rd_addr_reg[0] == BEAT1_SEL)
      else $error("read burst fetch wrong");

   a_rd_first_launch:
      assert property (rd_state_reg == RD_WAIT && beat0_edge
                       |=> read_data_oe_o && read_data_o == $past(nxt_w0_reg))
      else $error("first read word not launched");

   a_rd_second_launch:
      assert property (rd_state_reg == RD_BEAT_A && beat1_edge
                       |=> read_data_oe_o && read_data_o == $past(hold_w1_reg))
      else $error("second read word not launched");

   a_rd_float_after:
      assert property (rd_state_reg == RD_BEAT_B && pos_out_rise
                       && !(beat0_edge && nxt_full_reg) |=> !read_data_oe_o)
      else $error("read outputs still driven after burst");

   a_rd_idle_float:
      assert property (rd_state_reg == RD_IDLE |=> !read_data_oe_o)
      else $error("read outputs driven while idle");

endmodule

// file: verilog/sbs_pkg.sv
// shared constants and types for the split-port burst sram pin interface
// assumes: one core clock, all pins reach the core through two-flop synchronisers
package sbs_pkg;

   // data lane geometry
   localparam int LANE_W = 9;     // one byte lane carries nine bits
   localparam int DATA_W_X9 = 9;
   localparam int DATA_W_X18 = 18;
   localparam int DATA_W_X36 = 36;

   // burst address widths per data configuration
   localparam int ADDR_W_X9 = 21;
   localparam int ADDR_W_X18 = 20;
   localparam int ADDR_W_X36 = 19;

   // synchroniser depth on every pin
   localparam int SYNC_STAGES = 2;

   // core clock period, for reference when choosing pin clock rates
   localparam int CORE_CLK_PERIOD_NS = 4;

   // word index inside a two-word burst
   localparam logic BEAT0_SEL = 1'h0;
   localparam logic BEAT1_SEL = 1'h1;

   // burst address width follows the data width
   function automatic int addr_w_for(input int data_w);
      if (data_w == DATA_W_X9) begin
         return ADDR_W_X9;
      end else if (data_w == DATA_W_X18) begin
         return ADDR_W_X18;
      end
      return ADDR_W_X36;
   endfunction

   // write port sequencing
   typedef enum logic [2:0] {
      WR_IDLE  = 3'h1,
      WR_BEAT0 = 3'h2,
      WR_BEAT1 = 3'h4
   } sbs_wr_state_t;

   // read data launch sequencing
   typedef enum logic [3:0] {
      RD_IDLE   = 4'h1,
      RD_WAIT   = 4'h2,
      RD_BEAT_A = 4'h4,
      RD_BEAT_B = 4'h8
   } sbs_rd_state_t;

endpackage

// file: verilog/sbs_burst_mem.sv
// storage array for the burst sram, one word per beat, byte-lane writes
// assumes: the caller presents at most one write and one read per core cycle
module sbs_burst_mem
   import sbs_pkg::*;
#(
   parameter int DATA_W = 36,
   parameter int WORD_AW = 20
) (
   input wire logic core_clk_i,
   input wire logic wr_en_i,
   input wire logic [WORD_AW-1:0] wr_addr_i,
   input wire logic [DATA_W-1:0] wr_data_i,
   input wire logic [DATA_W/LANE_W-1:0] wr_lane_n_i,
   input wire logic rd_en_i,
   input wire logic [WORD_AW-1:0] rd_addr_i,
   output logic [DATA_W-1:0] rd_data_o
);

   localparam int LANES = DATA_W / LANE_W;

   logic [DATA_W-1:0] mem_array [0:(1<<WORD_AW)-1]; // no reset: contents are undefined at power-up
   logic [DATA_W-1:0] rd_data_reg;                    // read data leave from a register

   //////////////////////////////////////////////////////////////////////////////
   // lane-gated write and registered read; a read of a word written in the same
   // cycle returns the old contents, the sequencer never asks for that overlap
   always_ff @(posedge core_clk_i) begin
      if (wr_en_i) begin
         for (int l = 0; l < LANES; l++) begin
            // a lane whose select is high keeps its old byte
            if (!wr_lane_n_i[l]) begin
               mem_array[wr_addr_i][l*LANE_W +: LANE_W] <= wr_data_i[l*LANE_W +: LANE_W];
            end
         end
      end
      if (rd_en_i) begin
         rd_data_reg <= mem_array[rd_addr_i];
      end
   end

   assign rd_data_o = rd_data_reg;

endmodule

// file: tb/sbs_ctl_model.sv
// controller model: drives the pin clocks, port selects, address and write beats
// assumes: core_clk_i is the bench clock; each pin clock phase is held four core cycles
module sbs_ctl_model
   import sbs_pkg::*;
(
   input wire logic core_clk_i,
   output logic in_clk_o,
   output logic in_clk_n_o,
   output logic out_clk_o,
   output logic out_clk_n_o,
   output logic wsel_n_o,
   output logic rsel_n_o,
   output logic [DATA_W_X36/LANE_W-1:0] lanes_n_o,
   output logic [ADDR_W_X36-1:0] addr_o,
   output logic [DATA_W_X36-1:0] wdata_o
);
   timeunit 1ns;
   timeprecision 100ps;

   localparam int HALF = 4; // core cycles a phase; above the three-cycle floor of the pins
   logic c_en; // output clock pair runs; low holds it still for single clock mode

   ////////////////////////////////////////////////////////////////////////////////
   // idle levels: both ports deselected, clocks low
   initial begin
      c_en = 1'b1;
      {in_clk_o, in_clk_n_o, out_clk_o, out_clk_n_o} = 4'h0;
      {wsel_n_o, rsel_n_o} = 2'h3;
      lanes_n_o = 4'hF;
      addr_o = 19'h00000;
      wdata_o = 36'h0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // one input clock period; deselected cycles still drive the given lines, so a
   // port that wrongly listens to them corrupts the array or adds read words
   task automatic kcyc(input logic rs_n, input logic [18:0] ra, input logic ws_n,
                       input logic [18:0] wa, input logic [35:0] d0, input logic [3:0] m0,
                       input logic [35:0] d1, input logic [3:0] m1);
      @(posedge core_clk_i);
      in_clk_o <= 1'b1; // every access begins on this rise
      in_clk_n_o <= 1'b0;
      out_clk_o <= c_en; // output pair follows the input pair while c_en is high
      out_clk_n_o <= 1'b0;
      rsel_n_o <= rs_n; // selects set up for the positive rise
      wsel_n_o <= ws_n;
      addr_o <= ra; // read address on positive rise
      wdata_o <= d0; // first beat with its own mask
      lanes_n_o <= m0;
      repeat (HALF - 1) @(posedge core_clk_i);
      @(posedge core_clk_i);
      in_clk_o <= 1'b0;
      in_clk_n_o <= 1'b1;
      out_clk_o <= 1'b0;
      out_clk_n_o <= c_en;
      addr_o <= wa; // write address on negative rise
      wdata_o <= d1; // second beat on the next edge
      lanes_n_o <= m1;
      repeat (HALF - 1) @(posedge core_clk_i);
   endtask
endmodule

// file: tb/tb_top.sv
// self-checking bench for the split-port burst sram pin interface
// assumes: sbs_ctl_model plays the controller; read words are gathered while oe is high
module tb_top
   import sbs_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int LIMIT = 6000; // core cycles; the tests need well under a thousand
   localparam logic [18:0] A_TOP = 19'h7FFFF; // top burst location
   localparam logic [18:0] A_BOT = 19'h00000; // bottom burst location
   logic core_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic smode = 1'b0; // single clock mode level
   logic pll_n = 1'b1; // pll running
   logic in_clk, in_clk_n, out_clk, out_clk_n, wsel_n, rsel_n;
   logic [3:0] lanes_n;
   logic [18:0] addr;
   logic [35:0] wdata, read_data_o, prev_q, exp_q[$], got[$];
   logic read_data_oe_o, prev_oe;
   int failures = 0;
   int samples_checked = 0;
   int cycles = 0;

   sbs_ctl_model ctl (.core_clk_i(core_clk_i), .in_clk_o(in_clk), .in_clk_n_o(in_clk_n),
      .out_clk_o(out_clk), .out_clk_n_o(out_clk_n), .wsel_n_o(wsel_n), .rsel_n_o(rsel_n),
      .lanes_n_o(lanes_n), .addr_o(addr), .wdata_o(wdata));

   sbs_sram_io dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .in_clk_i(in_clk),
      .in_clk_n_i(in_clk_n), .out_clk_i(out_clk), .out_clk_n_i(out_clk_n),
      .single_clk_mode_i(smode), .pll_disable_n_i(pll_n), .write_port_select_n_i(wsel_n),
      .read_port_select_n_i(rsel_n), .byte_lane_write_select_n_i(lanes_n), .addr_i(addr),
      .write_data_i(wdata), .read_data_o(read_data_o), .read_data_oe_o(read_data_oe_o));

   ////////////////////////////////////////////////////////////////////////////////
   // 250 MHz core clock
   initial begin
      forever #2 core_clk_i = ~core_clk_i;
   end

   // gather each new word while driven; needs distinct adjacent words to see both
   always @(posedge core_clk_i) begin
      if (read_data_oe_o === 1'b1 && (prev_oe !== 1'b1 || read_data_o !== prev_q)) begin
         got.push_back(read_data_o);
      end
      prev_oe <= read_data_oe_o;
      prev_q <= read_data_o;
   end

   // hang guard
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == LIMIT) begin
         failures++;
         tally_and_finish();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // comparisons and closing
   task automatic check_word(input string nm, input logic [35:0] e, input logic [35:0] s);
      samples_checked++;
      if (s !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic check_flag(input string nm, input logic e, input logic s);
      samples_checked++;
      if (s !== e) begin
         failures++;
         $display("mismatch %s expected %b seen %b", nm, e, s);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // lanes whose select is high keep the old byte
   function automatic logic [35:0] merge(input logic [35:0] o, n, input logic [3:0] m);
      logic [35:0] r;
      for (int i = 0; i < 4; i++) begin
         r[i*9 +: 9] = m[i] ? o[i*9 +: 9] : n[i*9 +: 9];
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // bus helpers
   task automatic idle(input int n);
      repeat (n) ctl.kcyc(1'b1, 19'h0, 1'b1, 19'h0, 36'h0, 4'h0, 36'h0, 4'h0);
   endtask

   task automatic wr(input logic [18:0] a, input logic [35:0] d0, input logic [3:0] m0,
                     input logic [35:0] d1, input logic [3:0] m1);
      ctl.kcyc(1'b1, ~a, 1'b0, a, d0, m0, d1, m1);
   endtask

   // read issue; expected words are queued by the caller
   task automatic rd(input logic [18:0] a);
      ctl.kcyc(1'b0, a, 1'b1, 19'h0, 36'h0, 4'h0, 36'h0, 4'h0);
   endtask

   // let bursts finish, then compare gathered words and the floated outputs
   task automatic drain(input string nm);
      idle(4);
      #1;
      check_word({nm, " count"}, 36'(exp_q.size()), 36'(got.size()));
      foreach (exp_q[i]) check_word(nm, exp_q[i], i < got.size() ? got[i] : 36'hX);
      check_flag({nm, " oe"}, 1'b0, read_data_oe_o);
      exp_q.delete();
      got.delete();
      $display("test %s done", nm);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   localparam logic [35:0] D0 = 36'h123456789, D1 = 36'hABCDEF012;
   localparam logic [35:0] N0 = 36'h987654321, N1 = 36'h55AA5A55A;
   localparam logic [35:0] E0 = 36'h0F0F0F0F0, E1 = 36'hC3C3C3C3C;

   task automatic t_basic();
      check_word("addr width", 36'h13, 36'(dut.ADDR_W));
      wr(A_TOP, D0, 4'h0, D1, 4'h0);
      rd(A_TOP);
      exp_q = '{D0, D1};
      drain("basic");
   endtask

   task automatic t_lanes();
      wr(A_TOP, N0, 4'hA, N1, 4'h5);
      rd(A_TOP);
      exp_q = '{merge(D0, N0, 4'hA), merge(D1, N1, 4'h5)};
      drain("lanes");
   endtask

   task automatic t_desel();
      ctl.kcyc(1'b1, A_TOP, 1'b1, A_TOP, E0, 4'h0, E1, 4'h0);
      drain("deselected");
      rd(A_TOP);
      exp_q = '{merge(D0, N0, 4'hA), merge(D1, N1, 4'h5)};
      drain("kept");
   endtask

   task automatic t_concur();
      ctl.kcyc(1'b0, A_TOP, 1'b0, A_BOT, E0, 4'h0, E1, 4'h0);
      rd(A_BOT);
      rd(A_TOP);
      exp_q = '{merge(D0, N0, 4'hA), merge(D1, N1, 4'h5), E0, E1,
                merge(D0, N0, 4'hA), merge(D1, N1, 4'h5)};
      drain("concurrent");
   endtask

   task automatic t_modes();
      for (int p = 0; p < 2; p++) begin
         for (int s = 0; s < 2; s++) begin
            @(posedge core_clk_i);
            pll_n <= p[0];
            smode <= s[0];
            ctl.c_en <= ~s[0];
            idle(1);
            rd(A_BOT);
            exp_q = '{E0, E1};
            drain($sformatf("mode pll_n=%0d single=%0d", p, s));
         end
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (16) @(posedge core_clk_i);
      reset_i <= 1'b0;
      @(posedge core_clk_i);
      #1;
      check_flag("oe after reset", 1'b0, read_data_oe_o);
      check_word("data after reset", 36'h0, read_data_o);
      idle(1);
      t_basic();
      t_lanes();
      t_desel();
      t_concur();
      t_modes();
      tally_and_finish();
   end
endmodule
